//--- fet_sense_ctrl.sv
// Purpose: low-side FET current sense amplifier control with register file
// Assumes: AHB-Lite single word transfers, one clock, async active-low reset
// Notes:   zero wait states; read data is captured at the address phase
//
// Chosen here: the AHB-Lite register port and the address map.
module fet_sense_ctrl
    import fet_sense_pkg::*;
#(
    parameter int N = NUM_AMPS
) (
    // clock and reset
    input  wire logic          sys_clk_in,
    input  wire logic          rstn_in,
    // ahb-lite slave
    input  wire logic          hsel_in,
    input  wire logic [31:0]   haddr_in,
    input  wire logic [1:0]    htrans_in,
    input  wire logic          hwrite_in,
    input  wire logic [2:0]    hsize_in,
    input  wire logic [31:0]   hwdata_in,
    input  wire logic          hready_in,
    output logic [31:0]        hrdata_out,
    output logic               hreadyout_out,
    output logic               hresp_out,
    // gate commands from the host
    input  wire logic [N-1:0]  ls_cmd_in,
    input  wire logic [N-1:0]  hs_cmd_in,
    // gate drive
    output logic [N-1:0]       lowside_gate_output_out,
    output logic [N-1:0]       highside_gate_out,
    output logic [N-1:0]       gate_peak_current_out,
    output logic [N-1:0]       gate_hold_current_out,
    // amplifier control
    output logic [N-1:0]       amp_enable_out,
    output logic [N-1:0]       amp_input_short_out,
    output logic [N-1:0]       sense_amp_output_valid_out,
    output logic [N-1:0]       pos_from_switch_node_out,
    output logic [N-1:0]       ref_from_source_sense_out,
    output logic [2*N-1:0]     sense_gain_setting_out,
    output logic [N-1:0]       bias_half_ref_out,
    output logic [N-1:0]       bidir_sense_out,
    output logic [N-1:0]       offset_cal_out
);

    logic                      fet_q, fet_d;
    logic                      ref_q, ref_d;
    logic [PEAK_W-1:0]         peakset_q, peakset_d;
    logic [1:0]                gain_q [N];
    logic [1:0]                gain_d [N];
    logic [N-1:0]              bias_q, bias_d;
    logic [N-1:0]              bidir_q, bidir_d;
    logic [N-1:0]              cal_q, cal_d;
    logic [BLANK_W-1:0]        blank_q [N];
    logic [BLANK_W-1:0]        blank_d [N];
    logic                      wpend_q, wpend_d;
    logic [7:0]                waddr_q, waddr_d;
    logic [31:0]               rdata_q, rdata_d;
    logic [STAT_W*N-1:0]       status;
    logic                      take;

    // bus never stalls and never errors
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = rdata_q;
    assign take          = hsel_in && hready_in && htrans_in[1];

    // per-amplifier channels
    for (genvar i = 0; i < N; i++) begin : g_chan
        sense_chan_if ch_if ();

        assign ch_if.fet_mode     = fet_q;
        assign ch_if.lowside_ref_select = ref_q;
        assign ch_if.peak_cycles  = peakset_q;
        assign ch_if.blank_cycles = blank_q[i];

        sense_chan u_chan (
            .sys_clk_in (sys_clk_in),
            .rstn_in    (rstn_in),
            .ls_cmd_in  (ls_cmd_in[i]),
            .hs_cmd_in  (hs_cmd_in[i]),
            .ch         (ch_if.chan)
        );

        // pin outputs of this channel
        assign lowside_gate_output_out[i]    = ch_if.ls_gate;
        assign highside_gate_out[i]          = ch_if.hs_gate;
        assign gate_peak_current_out[i]      = ch_if.peak_active;
        assign gate_hold_current_out[i]      = !ch_if.peak_active;
        assign amp_enable_out[i]             = ch_if.amp_en;
        assign amp_input_short_out[i]        = ch_if.amp_short;
        assign sense_amp_output_valid_out[i] = ch_if.out_valid;
        assign pos_from_switch_node_out[i]   = ch_if.pos_sel_sw;
        assign ref_from_source_sense_out[i]  = ch_if.mon_ref_src;
        assign sense_gain_setting_out[2*i+:2] = gain_q[i];
        assign bias_half_ref_out[i]          = bias_q[i];
        assign bidir_sense_out[i]            = bidir_q[i];
        assign offset_cal_out[i]             = cal_q[i];
        assign status[STAT_W*i+:STAT_W]      = {ch_if.out_valid,
                                                ch_if.amp_short,
                                                ch_if.peak_active,
                                                ch_if.ls_gate};
    end

    // address phase capture and write of the pending data phase
    always_comb begin
        wpend_d   = take && hwrite_in;
        waddr_d   = take ? haddr_in[7:0] : waddr_q;
        fet_d     = fet_q;
        ref_d     = ref_q;
        peakset_d = peakset_q;
        bias_d    = bias_q;
        bidir_d   = bidir_q;
        cal_d     = cal_q;
        for (int i = 0; i < N; i++) begin
            gain_d[i]  = gain_q[i];
            blank_d[i] = blank_q[i];
        end
        if (wpend_q) begin
            if (waddr_q == CTRL_OFFS) begin
                fet_d     = hwdata_in[CTRL_FET_BIT];
                ref_d     = hwdata_in[CTRL_REF_BIT];
                peakset_d = hwdata_in[CTRL_PEAK_LSB+:PEAK_W];
            end
            for (int i = 0; i < N; i++) begin
                if (waddr_q == AMP0_OFFS + 8'(4 * i)) begin
                    gain_d[i]  = hwdata_in[AMP_GAIN_LSB+:2];
                    bias_d[i]  = hwdata_in[AMP_BIAS_BIT];
                    bidir_d[i] = hwdata_in[AMP_BIDIR_BIT];
                    cal_d[i]   = hwdata_in[AMP_CAL_BIT];
                    blank_d[i] = hwdata_in[AMP_BLANK_LSB+:BLANK_W];
                end
            end
        end
    end

    // read data captured at the address phase, zero for unmapped offsets
    always_comb begin
        rdata_d = rdata_q;
        if (take && !hwrite_in) begin
            rdata_d = 32'h0000_0000;
            if (haddr_in[7:0] == CTRL_OFFS) begin
                rdata_d[CTRL_FET_BIT]              = fet_q;
                rdata_d[CTRL_REF_BIT]              = ref_q;
                rdata_d[CTRL_PEAK_LSB+:PEAK_W]     = peakset_q;
            end
            if (haddr_in[7:0] == STATUS_OFFS) begin
                rdata_d[STAT_W*N-1:0]              = status;
            end
            for (int i = 0; i < N; i++) begin
                if (haddr_in[7:0] == AMP0_OFFS + 8'(4 * i)) begin
                    rdata_d[AMP_GAIN_LSB+:2]         = gain_q[i];
                    rdata_d[AMP_BIAS_BIT]            = bias_q[i];
                    rdata_d[AMP_BIDIR_BIT]           = bidir_q[i];
                    rdata_d[AMP_CAL_BIT]             = cal_q[i];
                    rdata_d[AMP_BLANK_LSB+:BLANK_W]  = blank_q[i];
                end
            end
        end
    end

    // register file flops
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wpend_q   <= 1'b0;
            waddr_q   <= 8'h00;
            rdata_q   <= 32'h0000_0000;
            fet_q     <= FET_RST;
            ref_q     <= REF_RST;
            peakset_q <= PEAK_RST;
            bias_q    <= '0;
            bidir_q   <= '0;
            cal_q     <= '0;
            for (int i = 0; i < N; i++) begin
                gain_q[i]  <= GAIN_RST;
                blank_q[i] <= BLANK_RST;
            end
        end else begin
            wpend_q   <= wpend_d;
            waddr_q   <= waddr_d;
            rdata_q   <= rdata_d;
            fet_q     <= fet_d;
            ref_q     <= ref_d;
            peakset_q <= peakset_d;
            bias_q    <= bias_d;
            bidir_q   <= bidir_d;
            cal_q     <= cal_d;
            for (int i = 0; i < N; i++) begin
                gain_q[i]  <= gain_d[i];
                blank_q[i] <= blank_d[i];
            end
        end
    end

endmodule : fet_sense_ctrl

//--- fet_sense_pkg.sv
// Purpose: shared constants for the low-side sense amplifier control block
// Assumes: 20 MHz system clock, 32-bit AHB-Lite register access
// Notes:   every offset, field position and count lives here, and every reset value but the zeros of bias, bidir and cal
package fet_sense_pkg;

    // clock, timing and amplifier count
    localparam int          CLK_HZ          = 20_000_000;
    localparam int          PEAK_TIME_NS    = 1000;
    localparam int          PEAK_CYCLES     =
        (PEAK_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int          BLANK_TIME_NS   = 200;
    localparam int          BLANK_CYCLES    =
        (BLANK_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int          NUM_AMPS        = 3;

    // register byte offsets
    localparam logic [7:0]  CTRL_OFFS       = 8'h00;
    localparam logic [7:0]  AMP0_OFFS       = 8'h04;
    localparam logic [7:0]  AMP1_OFFS       = 8'h08;
    localparam logic [7:0]  AMP2_OFFS       = 8'h0C;
    localparam logic [7:0]  STATUS_OFFS     = 8'h10;

    // control register fields
    localparam int          CTRL_FET_BIT    = 0;
    localparam int          CTRL_REF_BIT    = 1;
    localparam int          CTRL_PEAK_LSB   = 8;
    localparam int          PEAK_W          = 8;

    // per-amplifier register fields
    localparam int          AMP_GAIN_LSB    = 0;
    localparam int          AMP_BIAS_BIT    = 2;
    localparam int          AMP_BIDIR_BIT   = 3;
    localparam int          AMP_CAL_BIT     = 4;
    localparam int          AMP_BLANK_LSB   = 8;
    localparam int          BLANK_W         = 4;

    // status register: four bits per amplifier
    localparam int          STAT_W          = 4;

    // reset values
    localparam logic        FET_RST         = 1'b0;
    localparam logic        REF_RST         = 1'b0;
    localparam logic [PEAK_W-1:0]  PEAK_RST  = PEAK_W'(PEAK_CYCLES);
    localparam logic [BLANK_W-1:0] BLANK_RST = BLANK_W'(BLANK_CYCLES);

    // gain codes
    localparam logic [1:0]  GAIN_5          = 2'h0;
    localparam logic [1:0]  GAIN_10         = 2'h1;
    localparam logic [1:0]  GAIN_20         = 2'h2;
    localparam logic [1:0]  GAIN_40         = 2'h3;
    localparam logic [1:0]  GAIN_RST        = GAIN_10;

    // amplifier sequence, gray coded along the usual path
    typedef enum logic [1:0] {
        AMP_OFF   = 2'h0,
        AMP_WAIT  = 2'h1,
        AMP_BLANK = 2'h3,
        AMP_VALID = 2'h2
    } amp_state_e;

endpackage : fet_sense_pkg

//--- sense_chan_if.sv
// Purpose: settings to and state from one sense amplifier channel
// Assumes: single clock domain
// Notes:   cfg side is the register file, chan side the channel logic
interface sense_chan_if;
    import fet_sense_pkg::*;

    logic               fet_mode;
    logic               lowside_ref_select;
    logic [PEAK_W-1:0]  peak_cycles;
    logic [BLANK_W-1:0] blank_cycles;
    logic               ls_gate;
    logic               hs_gate;
    logic               peak_active;
    logic               amp_en;
    logic               amp_short;
    logic               out_valid;
    logic               mon_ref_src;
    logic               pos_sel_sw;

    modport cfg (
        output fet_mode, lowside_ref_select, peak_cycles, blank_cycles,
        input  ls_gate, hs_gate, peak_active, amp_en, amp_short,
        input  out_valid, mon_ref_src, pos_sel_sw
    );
    modport chan (
        input  fet_mode, lowside_ref_select, peak_cycles, blank_cycles,
        output ls_gate, hs_gate, peak_active, amp_en, amp_short,
        output out_valid, mon_ref_src, pos_sel_sw
    );
endinterface : sense_chan_if

//--- sense_chan.sv
// Purpose: gate peak interval and amplifier enable sequence for one phase
// Assumes: gate commands arrive asynchronously from the host pins
// Notes:   commands pass three flops; a change counts when flops 2 and 3 agree
module sense_chan
    import fet_sense_pkg::*;
(
    // clock and reset
    input  wire logic   sys_clk_in,
    input  wire logic   rstn_in,
    // raw gate commands
    input  wire logic   ls_cmd_in,
    input  wire logic   hs_cmd_in,
    // settings and state
    sense_chan_if.chan  ch
);

    logic [2:0]         ls_sync_q, ls_sync_d;
    logic [2:0]         hs_sync_q, hs_sync_d;
    logic               ls_q, ls_d;
    logic               hs_q, hs_d;
    logic [PEAK_W-1:0]  peak_q, peak_d;
    logic [BLANK_W-1:0] blank_q, blank_d;
    amp_state_e         st_q, st_d;
    logic               change;
    logic               ls_rise;
    logic               peak_end;

    // synchroniser shift and agreement filter
    always_comb begin
        ls_sync_d = {ls_sync_q[1:0], ls_cmd_in};
        hs_sync_d = {hs_sync_q[1:0], hs_cmd_in};
        ls_d      = (ls_sync_q[1] == ls_sync_q[2]) ? ls_sync_q[2] : ls_q;
        hs_d      = (hs_sync_q[1] == hs_sync_q[2]) ? hs_sync_q[2] : hs_q;
        change    = (ls_d != ls_q) || (hs_d != hs_q);
        ls_rise   = ls_d && !ls_q;
    end

    // peak drive timer: any new command restarts it, cutting the old one
    always_comb begin
        peak_end = (peak_q == PEAK_W'(1)) && !change;
        if (change) begin
            peak_d = (ch.peak_cycles == '0) ? PEAK_W'(1) : ch.peak_cycles;
        end else if (peak_q != '0) begin
            peak_d = peak_q - PEAK_W'(1);
        end else begin
            peak_d = peak_q;
        end
    end

    // amplifier enable sequence for low-side sensing
    always_comb begin
        st_d = st_q;
        case (st_q)
            AMP_OFF: begin
                if (ls_rise) begin
                    st_d = AMP_WAIT;
                end
            end
            AMP_WAIT: begin
                if (peak_end) begin
                    st_d = AMP_BLANK;
                end
            end
            AMP_BLANK: begin
                if (blank_q == '0) begin
                    st_d = AMP_VALID;
                end
            end
            AMP_VALID: begin
                st_d = AMP_VALID;
            end
            default: begin
                st_d = AMP_OFF;
            end
        endcase
        if (ls_rise) begin
            st_d = AMP_WAIT;
        end
        if (!ls_d || !ch.fet_mode) begin
            st_d = AMP_OFF;
        end
    end

    // blanking timer, started at amplifier enable in fet mode, at any gate change otherwise
    always_comb begin
        if (ch.fet_mode ? (st_q == AMP_WAIT && st_d == AMP_BLANK)
                        : change) begin
            blank_d = ch.blank_cycles;
        end else if (blank_q != '0) begin
            blank_d = blank_q - BLANK_W'(1);
        end else begin
            blank_d = blank_q;
        end
    end

    // state registers
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ls_sync_q <= 3'h0;
            hs_sync_q <= 3'h0;
            ls_q      <= 1'b0;
            hs_q      <= 1'b0;
            peak_q    <= '0;
            blank_q   <= '0;
            st_q      <= AMP_OFF;
        end else begin
            ls_sync_q <= ls_sync_d;
            hs_sync_q <= hs_sync_d;
            ls_q      <= ls_d;
            hs_q      <= hs_d;
            peak_q    <= peak_d;
            blank_q   <= blank_d;
            st_q      <= st_d;
        end
    end

    // decoded channel outputs
    assign ch.ls_gate     = ls_q;
    assign ch.hs_gate     = hs_q;
    assign ch.peak_active = (peak_q != '0);
    assign ch.amp_en      = ch.fet_mode ? (st_q == AMP_BLANK ||
                                           st_q == AMP_VALID)
                                        : 1'b1;
    assign ch.amp_short   = ch.fet_mode && (st_q == AMP_OFF);
    assign ch.out_valid   = ch.fet_mode ? (st_q == AMP_VALID)
                                        : (blank_q == '0);
    assign ch.mon_ref_src = ch.fet_mode || ch.lowside_ref_select;
    assign ch.pos_sel_sw  = ch.fet_mode;

endmodule : sense_chan

//--- fet_sense_monitor.sv
// Purpose: concurrent checks on the amplifier control outputs of phase 0, and on reference and hold current of all phases
// Assumes: one clock, asynchronous active-low reset
// Notes:   sees only top-level ports; attached by bind from the bench
module fet_sense_monitor
    import fet_sense_pkg::*;
#(
    parameter int N = NUM_AMPS
) (
    // clock and reset
    input wire logic         sys_clk_in,
    input wire logic         rstn_in,
    // gate drive
    input wire logic [N-1:0] lowside_gate_output_out,
    input wire logic [N-1:0] gate_peak_current_out,
    input wire logic [N-1:0] gate_hold_current_out,
    // amplifier control
    input wire logic [N-1:0] amp_enable_out,
    input wire logic [N-1:0] amp_input_short_out,
    input wire logic [N-1:0] sense_amp_output_valid_out,
    input wire logic [N-1:0] pos_from_switch_node_out,
    input wire logic [N-1:0] ref_from_source_sense_out
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    // reference of every phase, shorting and enable ordering of phase 0
    ref_select_a: assert property (
        (pos_from_switch_node_out & ~ref_from_source_sense_out) == '0)
        else $error("monitor reference not source sense in fet mode");
    short_gate_low_a: assert property (
        pos_from_switch_node_out[0] && !lowside_gate_output_out[0]
        |-> amp_input_short_out[0]) else $error("inputs open, gate low");
    enable_after_peak_a: assert property (
        pos_from_switch_node_out[0] && $rose(amp_enable_out[0])
        |-> !gate_peak_current_out[0] && $past(gate_peak_current_out[0]))
        else $error("amplifier enabled outside peak end");
    peak_on_change_a: assert property (
        $changed(lowside_gate_output_out[0])
        |-> gate_peak_current_out[0] && !gate_hold_current_out[0])
        else $error("no peak current after gate change");
    hold_inverse_a: assert property (
        gate_hold_current_out == ~gate_peak_current_out)
        else $error("hold current not inverse of peak");
    blank_before_valid_a: assert property (
        pos_from_switch_node_out[0] && $rose(sense_amp_output_valid_out[0])
        |-> amp_enable_out[0] && $past(amp_enable_out[0]))
        else $error("output valid without blanking");
    turnoff_disable_a: assert property (
        pos_from_switch_node_out[0] && $fell(lowside_gate_output_out[0])
        |-> amp_input_short_out[0] && !amp_enable_out[0]
            && !sense_amp_output_valid_out[0])
        else $error("amplifier live after turn-off");
    turnon_wait_a: assert property (
        pos_from_switch_node_out[0] && $rose(lowside_gate_output_out[0])
        |-> !amp_input_short_out[0] && !amp_enable_out[0])
        else $error("turn-on did not restart sequence");
    valid_needs_gate_a: assert property (
        pos_from_switch_node_out[0] && sense_amp_output_valid_out[0]
        |-> amp_enable_out[0] && lowside_gate_output_out[0])
        else $error("output valid with gate off");

    // main scenarios reached
    cover property (pos_from_switch_node_out[0]
        && $rose(sense_amp_output_valid_out[0]));
    cover property (pos_from_switch_node_out[0]
        && $fell(lowside_gate_output_out[0]));
    cover property ($rose(gate_peak_current_out[1]));
endmodule : fet_sense_monitor

//--- gate_cmd_host.sv
// Purpose: host pin driver standing in for the gate command source
// Assumes: requests come from the bench on the clock edge
// Notes:   pins move mid-cycle, unrelated to the block's sampling
module gate_cmd_host
    import fet_sense_pkg::*;
(
    // clock
    input  wire logic                sys_clk_in,
    // requested levels
    input  wire logic [NUM_AMPS-1:0] ls_req_in,
    input  wire logic [NUM_AMPS-1:0] hs_req_in,
    // pins to the block
    output logic      [NUM_AMPS-1:0] ls_cmd_out,
    output logic      [NUM_AMPS-1:0] hs_cmd_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // a low side request yields to high side; pins settle during reset
    always @(posedge sys_clk_in) begin
        ls_cmd_out <= #12 ls_req_in & ~hs_req_in; // no shoot-through
        hs_cmd_out <= #12 hs_req_in;
    end
endmodule : gate_cmd_host

//--- tb_top.sv
// Purpose: self-checking bench for the low-side sense control block
// Assumes: zero-wait bus slave, gate filter of three flops
// Notes:   reset values first, then register rows, sequence, edge cases and a mid-run reset
module tb_top
    import fet_sense_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct { int amp; logic [31:0] val; } row_s;
    logic        sys_clk_in = 1'b0;
    logic        rstn_in    = 1'b0;
    logic        hsel_in    = 1'b0;
    logic        hwrite_in  = 1'b0;
    logic        hready_in;
    logic [31:0] haddr_in   = '0;
    logic [31:0] hwdata_in  = '0;
    logic [1:0]  htrans_in  = '0;
    logic [2:0]  hsize_in   = 3'h2;
    logic [2:0]  ls_req     = '0;
    logic [2:0]  hs_req     = '0;
    logic [2:0]  ls_cmd_in, hs_cmd_in, lowside_gate_output_out;
    logic [2:0]  highside_gate_out, gate_peak_current_out;
    logic [2:0]  gate_hold_current_out, amp_enable_out;
    logic [2:0]  amp_input_short_out, sense_amp_output_valid_out;
    logic [2:0]  pos_from_switch_node_out, ref_from_source_sense_out;
    logic [2:0]  bias_half_ref_out, bidir_sense_out, offset_cal_out;
    logic [5:0]  sense_gain_setting_out;
    logic [31:0] hrdata_out;
    logic        hreadyout_out, hresp_out, en_seen;
    logic [31:0] shadow [3] = '{32'h0000_0401, 32'h0000_0401, 32'h0000_0401};
    int          n_mismatch = 0;
    int          checked    = 0;
    row_s        rows [6]   = '{'{0, 32'h0000_0210}, '{0, 32'h0000_0306},
        '{1, 32'h0000_030B}, '{2, 32'h0000_0F1F}, '{1, 32'h0000_0004},
        '{0, 32'h0000_0105}};

    always #25 sys_clk_in = ~sys_clk_in;
    assign hready_in = hreadyout_out; // single slave drives bus ready

    fet_sense_ctrl #(.N(NUM_AMPS)) dut_u (.*);
    gate_cmd_host host_u (.sys_clk_in(sys_clk_in), .ls_req_in(ls_req),
        .hs_req_in(hs_req), .ls_cmd_out(ls_cmd_in), .hs_cmd_out(hs_cmd_in));

    task final_report;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task chk_bits(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_bits

    // one bus phase: hold until hready is seen high at an edge
    task bus_wait;
        int i;
        i = 0;
        do begin
            @(posedge sys_clk_in);
            i++;
        end while (hreadyout_out !== 1'b1 && i < 16);
        if (hreadyout_out !== 1'b1) begin
            n_mismatch++;
            final_report;
        end
    endtask : bus_wait

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] rd);
        @(posedge sys_clk_in);
        hsel_in   <= 1'b1;
        haddr_in  <= {24'h0, a};
        htrans_in <= 2'h2;
        hwrite_in <= w;
        bus_wait;
        hsel_in   <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        bus_wait;
        rd = hrdata_out;
        @(negedge sys_clk_in); // let stored fields settle
    endtask : ahb

    function automatic logic cond(int s);
        case (s)
            0: return lowside_gate_output_out[0];
            1: return amp_enable_out[0];
            2: return sense_amp_output_valid_out[0];
            3: return !lowside_gate_output_out[0];
            default: return highside_gate_out[1];
        endcase
    endfunction : cond

    // counts falling edges until the chosen condition holds
    task wait_for(input int s, output int c);
        c = 0;
        while (cond(s) !== 1'b1 && c < 64) begin
            @(negedge sys_clk_in);
            en_seen = en_seen | amp_enable_out[0];
            c++;
        end
        if (c >= 64) begin
            n_mismatch++;
            final_report;
        end
    endtask : wait_for

    // main sequence
    initial begin : main
        int c;
        logic [31:0] rd;
        repeat (3) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        @(negedge sys_clk_in);
        chk_bits("gain", 8'h15, {2'h0, sense_gain_setting_out});
        chk_bits("hold", 8'h07, {5'h0, gate_hold_current_out});
        chk_bits("en", 8'h07, {5'h0, amp_enable_out});
        chk_bits("valid", 8'h07,
            {5'h0, sense_amp_output_valid_out});
        chk_bits("resp", 8'h00, {7'h0, hresp_out});
        ahb(0, CTRL_OFFS, '0, rd);
        chk_word("ctrl", 32'h0000_1400, rd);
        ahb(0, AMP1_OFFS, '0, rd);
        chk_word("amp1", 32'h0000_0401, rd);
        ahb(1, 8'h20, 32'hFFFF_FFFF, rd);
        ahb(0, 8'h20, '0, rd);
        chk_word("unmapped", '0, rd);
        foreach (rows[i]) begin
            int a;
            a = rows[i].amp;
            ahb(1, AMP0_OFFS + 8'(4 * a), rows[i].val, rd);
            shadow[a] = rows[i].val & 32'h0000_0F1F;
            ahb(0, AMP0_OFFS + 8'(4 * a), '0, rd);
            chk_word("amp", shadow[a], rd);
            chk_bits("gain", {6'h0, rows[i].val[1:0]},
                {6'h0, sense_gain_setting_out[2*a +: 2]});
            chk_bits("bias", {7'h0, rows[i].val[2]},
                {7'h0, bias_half_ref_out[a]});
            chk_bits("bidir", {7'h0, rows[i].val[3]},
                {7'h0, bidir_sense_out[a]});
            chk_bits("cal", {7'h0, rows[i].val[4]},
                {7'h0, offset_cal_out[a]});
        end
        for (int a = 0; a < 3; a++) begin
            chk_bits("held gain", {6'h0, shadow[a][1:0]},
                {6'h0, sense_gain_setting_out[2*a +: 2]});
        end
        ahb(1, CTRL_OFFS, 32'h0000_0302, rd);
        chk_bits("ref", 8'h07, {5'h0, ref_from_source_sense_out});
        chk_bits("pos", 8'h00, {5'h0, pos_from_switch_node_out});
        ahb(1, CTRL_OFFS, 32'h0000_0301, rd);
        chk_bits("ref", 8'h07, {5'h0, ref_from_source_sense_out});
        chk_bits("pos", 8'h07, {5'h0, pos_from_switch_node_out});
        chk_bits("short", 8'h07, {5'h0, amp_input_short_out});
        @(posedge sys_clk_in);
        ls_req <= 3'h1;
        wait_for(0, c);
        chk_bits("short", 8'h00, {7'h0, amp_input_short_out[0]});
        chk_bits("peak", 8'h01, {7'h0, gate_peak_current_out[0]});
        wait_for(1, c);
        chk_bits("peak cycles", 8'h03, 8'(c));
        wait_for(2, c);
        chk_bits("blank cycles", 8'h02, 8'(c));
        ahb(0, STATUS_OFFS, '0, rd);
        chk_word("status", 32'h0000_0449, rd);
        @(posedge sys_clk_in);
        ls_req <= 3'h0;
        wait_for(3, c);
        chk_bits("short", 8'h01, {7'h0, amp_input_short_out[0]});
        chk_bits("valid", 8'h00, {5'h0, sense_amp_output_valid_out});
        ahb(1, CTRL_OFFS, 32'h0000_0801, rd);
        en_seen = 1'b0;
        @(posedge sys_clk_in);
        ls_req <= 3'h1;
        repeat (3) @(posedge sys_clk_in);
        ls_req <= 3'h0;
        wait_for(0, c);
        wait_for(3, c);
        chk_bits("enabled", 8'h00, {7'h0, en_seen});
        chk_bits("short", 8'h01, {7'h0, amp_input_short_out[0]});
        @(posedge sys_clk_in);
        hs_req <= 3'h2;
        wait_for(4, c);
        chk_bits("hs peak", 8'h01, {7'h0, gate_peak_current_out[1]});
        chk_bits("hs hold", 8'h00, {7'h0, gate_hold_current_out[1]});
        @(posedge sys_clk_in);
        hs_req <= 3'h0;
        repeat (20) @(negedge sys_clk_in);
        // reset in mid-run returns settings and shunt mode
        @(posedge sys_clk_in);
        rstn_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        ahb(0, CTRL_OFFS, '0, rd);
        chk_word("ctrl", 32'h0000_1400, rd);
        chk_bits("gain", 8'h15, {2'h0, sense_gain_setting_out});
        chk_bits("short", 8'h00, {5'h0, amp_input_short_out});
        final_report;
    end
endmodule : tb_top

bind fet_sense_ctrl fet_sense_monitor #(.N(N)) mon_u (.*);
